// ### src/dps_pkg.sv
package dps_pkg;
    localparam logic [11:0] ADDR_MASK       = 12'h000;
    localparam logic [11:0] ADDR_MODEL      = 12'h004;
    localparam logic [11:0] ADDR_CONFIG     = 12'h008;
    localparam logic [11:0] ADDR_RATED_I    = 12'h00C;
    localparam logic [11:0] ADDR_FAULTS     = 12'h010;
    localparam logic [11:0] ADDR_ALARMS     = 12'h014;
    localparam logic [11:0] ADDR_CODE       = 12'h018;
    localparam logic [11:0] ADDR_CLEAR      = 12'h01C;
    localparam logic [11:0] ADDR_SW_FREQ    = 12'h020;

    localparam logic [15:0] MASK_RESET      = 16'h0003;
    localparam logic [15:0] MASK_IMPL       = 16'h00BF;
    localparam int          MB_GROUND       = 0;
    localparam int          MB_MOD_OVL      = 1;
    localparam int          MB_MOTOR_OT     = 2;
    localparam int          MB_BIT3         = 3;
    localparam int          MB_BIT4         = 4;
    localparam int          MB_BIT5         = 5;
    localparam int          MB_PANEL        = 7;

    // fault vector positions
    localparam int          FV_GROUND       = 0;
    localparam int          FV_MOD_OVL      = 1;
    localparam int          FV_MOTOR_OT     = 2;
    localparam int          FV_BIT3         = 3;
    localparam int          FV_BIT4         = 4;
    localparam int          FV_BIT5         = 5;
    localparam int          FV_PANEL        = 6;
    localparam int          FV_MOD_OT       = 7;
    localparam int          FV_OVERCUR      = 8;
    localparam int          FV_UNDERV       = 9;
    localparam int          FV_OVERV        = 10;
    localparam int          FV_OPTION       = 11;
    localparam int          FV_TUNING       = 12;
    localparam int          FV_HWID         = 13;
    localparam int          FV_FIRMWARE     = 14;
    localparam int          NFAULT          = 15;

    // alarm vector positions
    localparam int          AV_MOD_OT       = 0;
    localparam int          AV_PANEL        = 1;

    // config bits
    localparam int          CFG_DERATE_OFF  = 0;
    localparam int          CFG_AI1_SHIFT   = 4;
    localparam int          CFG_AI2_SHIFT   = 8;
    localparam int          CFG_PANEL_SEL   = 12;
    localparam int          CFG_PANEL_SRC   = 13;
    localparam int          CFG_VVW_TUNE    = 14;
    localparam logic [3:0]  AI_FUNC_THERM   = 4'h4;

    // analog input limits in millivolts, then the alarm offset in degrees C and the switching frequencies in Hz
    localparam logic [15:0] THERM_HI_MV     = 16'd9100;
    localparam logic [15:0] THERM_LO_MV     = 16'd1300;
    localparam logic [7:0]  ALARM_OFFSET_C  = 8'd5;
    localparam logic [15:0] DERATE_FREQ_HZ  = 16'd2500;
    localparam logic [15:0] SW_FREQ_RESET   = 16'd5000;

    localparam logic [15:0] UV_LOW          = 16'd200;
    localparam logic [15:0] UV_MID          = 16'd360;
    localparam logic [15:0] UV_HIGH         = 16'd500;
    localparam logic [15:0] OV_LOW          = 16'd410;
    localparam logic [15:0] OV_MID          = 16'd810;
    localparam logic [15:0] OV_HIGH         = 16'd1000;

    localparam logic [7:0]  MODEL_RESET     = 8'd1;
    localparam logic [15:0] RATED_I_RESET   = 16'd100;

    typedef struct packed {
        logic [15:0] mask_q;
        logic [7:0]  model_q;
        logic [15:0] config_q;
        logic [15:0] rated_q;
        logic [15:0] sw_freq_q;
        logic [NFAULT-1:0] faults_q;
        logic [7:0]  code_q;
        logic [1:0]  alarms_q;
        logic        pwm_block_q;
        logic [31:0] prdata_q;
        logic        pslverr_q;
    } dps_state_t;

    typedef struct packed {
        logic [15:0] module_temp_c;
        logic [15:0] output_current;
        logic [15:0] link_voltage;
        logic [1:0]  supply_class;
        logic [15:0] ai1_mv;
        logic [15:0] ai2_mv;
    } dps_meas_t;
endpackage : dps_pkg

// ### src/dps_top.sv
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module dps_top
    import dps_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire dps_meas_t   meas,
    input  wire logic        phase_surge,
    input  wire logic        earth_surge,
    input  wire logic        module_overload,
    input  wire logic        ext_fault3,
    input  wire logic        ext_fault4,
    input  wire logic        ext_fault5,
    input  wire logic        option_present,
    input  wire logic        option_comm_ok,
    input  wire logic        tuning_done,
    input  wire logic        stator_edit,
    input  wire logic        stator_too_high,
    input  wire logic        panel_comm_ok,
    input  wire logic        hwid_check_done,
    input  wire logic        hwid_check_fail,
    input  wire logic        firmware_error,
    input  wire logic [7:0]  power_hw_model_code_unused,
    output logic             pwm_enable,
    output logic             fault_active,
    output logic             alarm_active
);
    dps_state_t s_q, s_d;
    logic [1:0] phase_sync_q, earth_sync_q, pcomm_sync_q;
    logic [NFAULT-1:0] raw;
    logic [7:0] fault_lvl, alarm_lvl, derate_lvl;
    logic [15:0] temp;
    logic [15:0] uv_lvl, ov_lvl;
    logic therm1, therm2;
    logic apb_wr, apb_rd, rd_setup;

    // fault level per model; index 0 and above 38 are unknown models
    function automatic logic [7:0] model_level(input logic [7:0] m);
        logic [7:0] l;
        l = 8'd90;
        unique case (m)
            8'd1, 8'd2, 8'd3:                      l = 8'd90;
            8'd4, 8'd11, 8'd16, 8'd36, 8'd37, 8'd38: l = 8'd105;
            8'd5:                                  l = 8'd123;
            8'd6, 8'd7, 8'd8, 8'd9, 8'd14, 8'd15:   l = 8'd108;
            8'd10, 8'd18:                          l = 8'd120;
            8'd12, 8'd13:                          l = 8'd115;
            default:                               l = (m >= 8'd17 && m <= 8'd35) ? 8'd110 : 8'd90;
        endcase
        return l;
    endfunction : model_level

    // surge pins are asynchronous; pwm gating still acts without waiting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_sync_q <= 2'b00;
            earth_sync_q <= 2'b00;
            pcomm_sync_q <= 2'b11;
        end else begin
            phase_sync_q <= {phase_sync_q[0], phase_surge};
            earth_sync_q <= {earth_sync_q[0], earth_surge};
            pcomm_sync_q <= {pcomm_sync_q[0], panel_comm_ok};
        end
    end

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign temp   = meas.module_temp_c;

    always_comb begin
        fault_lvl  = model_level(s_q.model_q);
        alarm_lvl  = fault_lvl - ALARM_OFFSET_C;
        derate_lvl = 8'((16'(fault_lvl) * 16'd4) / 16'd5);
        unique case (meas.supply_class)
            2'd0:    begin uv_lvl = UV_LOW;  ov_lvl = OV_LOW;  end
            2'd1:    begin uv_lvl = UV_MID;  ov_lvl = OV_MID;  end
            default: begin uv_lvl = UV_HIGH; ov_lvl = OV_HIGH; end
        endcase
        // only analog inputs evaluate the thermistor, never a digital input
        therm1 = (s_q.config_q[CFG_AI1_SHIFT +: 4] == AI_FUNC_THERM) &&
                 (meas.ai1_mv > THERM_HI_MV || meas.ai1_mv < THERM_LO_MV);
        therm2 = (s_q.config_q[CFG_AI2_SHIFT +: 4] == AI_FUNC_THERM) &&
                 (meas.ai2_mv > THERM_HI_MV || meas.ai2_mv < THERM_LO_MV);
        raw = '0;
        raw[FV_GROUND]   = earth_sync_q[1] & s_q.mask_q[MB_GROUND];
        raw[FV_MOD_OVL]  = module_overload & s_q.mask_q[MB_MOD_OVL];
        raw[FV_MOTOR_OT] = (therm1 | therm2) & s_q.mask_q[MB_MOTOR_OT];
        raw[FV_BIT3]     = ext_fault3 & s_q.mask_q[MB_BIT3];
        raw[FV_BIT4]     = ext_fault4 & s_q.mask_q[MB_BIT4];
        raw[FV_BIT5]     = ext_fault5 & s_q.mask_q[MB_BIT5];
        raw[FV_PANEL]    = s_q.config_q[CFG_PANEL_SEL] & s_q.config_q[CFG_PANEL_SRC] &
                           ~pcomm_sync_q[1] & s_q.mask_q[MB_PANEL];
        raw[FV_MOD_OT]   = temp >= 16'(fault_lvl);
        raw[FV_OVERCUR]  = phase_sync_q[1];
        raw[FV_UNDERV]   = meas.link_voltage < uv_lvl;
        raw[FV_OVERV]    = meas.link_voltage > ov_lvl;
        raw[FV_OPTION]   = option_present & ~option_comm_ok;
        raw[FV_TUNING]   = ((tuning_done & s_q.config_q[CFG_VVW_TUNE]) | stator_edit) &
                           stator_too_high;
        raw[FV_HWID]     = hwid_check_done & hwid_check_fail;
        raw[FV_FIRMWARE] = firmware_error;

        s_d = s_q;
        s_d.pslverr_q = 1'b0;
        // alarms follow their condition, no latching
        s_d.alarms_q[AV_MOD_OT] = temp >= 16'(alarm_lvl);
        s_d.alarms_q[AV_PANEL]  = s_q.config_q[CFG_PANEL_SEL] & ~pcomm_sync_q[1] &
                                  s_q.mask_q[MB_PANEL];
        if (!s_q.config_q[CFG_DERATE_OFF] && temp >= 16'(derate_lvl) &&
            meas.output_current > s_q.rated_q) begin
            s_d.sw_freq_q = DERATE_FREQ_HZ;
        end
        if (apb_wr) begin
            unique case (paddr)
                ADDR_MASK:    s_d.mask_q    = pwdata[15:0] & MASK_IMPL;
                ADDR_MODEL:   s_d.model_q   = pwdata[7:0];
                ADDR_CONFIG:  s_d.config_q  = pwdata[15:0];
                ADDR_RATED_I: s_d.rated_q   = pwdata[15:0];
                ADDR_SW_FREQ: s_d.sw_freq_q = pwdata[15:0];
                ADDR_CLEAR:   begin
                    s_d.faults_q = '0;
                    s_d.code_q   = '0;
                end
                ADDR_FAULTS, ADDR_ALARMS, ADDR_CODE: ;
                default:      s_d.pslverr_q = 1'b1;
            endcase
        end
        // set wins over a clear in the same cycle
        s_d.faults_q = s_d.faults_q | raw;
        if (s_d.code_q == 8'h00) begin
            for (int i = NFAULT - 1; i >= 0; i--) begin
                if (raw[i]) begin
                    s_d.code_q = 8'(i + 1);
                end
            end
        end
        s_d.pwm_block_q = |s_d.faults_q;
        // unmapped read answers with an error in the access phase
        if (apb_rd && !(paddr inside {ADDR_MASK, ADDR_MODEL, ADDR_CONFIG, ADDR_RATED_I,
                                      ADDR_FAULTS, ADDR_ALARMS, ADDR_CODE, ADDR_CLEAR,
                                      ADDR_SW_FREQ})) begin
            s_d.pslverr_q = 1'b1;
        end
        // read word captured at setup so it stands through the access phase
        if (rd_setup) begin
            s_d.prdata_q = '0;
            unique case (paddr)
                ADDR_MASK:    s_d.prdata_q[15:0] = s_q.mask_q;
                ADDR_MODEL:   s_d.prdata_q[7:0]  = s_q.model_q;
                ADDR_CONFIG:  s_d.prdata_q[15:0] = s_q.config_q;
                ADDR_RATED_I: s_d.prdata_q[15:0] = s_q.rated_q;
                ADDR_FAULTS:  s_d.prdata_q[NFAULT-1:0] = s_q.faults_q;
                ADDR_ALARMS:  s_d.prdata_q[1:0]  = s_q.alarms_q;
                ADDR_CODE:    s_d.prdata_q[7:0]  = s_q.code_q;
                ADDR_SW_FREQ: s_d.prdata_q[15:0] = s_q.sw_freq_q;
                ADDR_CLEAR:   ;
                default:      ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q           <= '0;
            s_q.mask_q    <= MASK_RESET;
            s_q.model_q   <= MODEL_RESET;
            s_q.rated_q   <= RATED_I_RESET;
            s_q.sw_freq_q <= SW_FREQ_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata       = s_q.prdata_q;
    assign pready       = 1'b1;
    assign pslverr      = psel & penable & (s_d.pslverr_q);
    // raw surge input cuts pulses at once, before any latch or firmware
    assign pwm_enable   = ~s_q.pwm_block_q & ~phase_surge & ~earth_surge;
    assign fault_active = s_q.pwm_block_q;
    assign alarm_active = |s_q.alarms_q;
endmodule : dps_top

// ### tb/dps_plant.sv
`timescale 1ns/100ps
module dps_plant
    import dps_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        pwm_enable,
    input  wire logic [15:0] temp_c,
    input  wire logic [15:0] volts,
    input  wire logic [15:0] amps,
    input  wire logic [15:0] ai_mv,
    input  wire logic [1:0]  cls,
    output dps_meas_t        meas
);
    // blocked pulses carry no output current
    always_ff @(posedge pclk) begin
        meas <= '{temp_c, pwm_enable ? amps : 16'h0000, volts, cls, ai_mv, 16'h0000};
    end
endmodule : dps_plant

// ### tb/dps_top_properties.sv
`timescale 1ns/100ps
module dps_top_properties
    import dps_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire dps_meas_t   meas,
    input wire logic        phase_surge,
    input wire logic        earth_surge,
    input wire logic        option_present,
    input wire logic        option_comm_ok,
    input wire logic        pwm_enable,
    input wire logic        fault_active,
    input wire logic        alarm_active
);
    logic clr;
    assign clr = psel && penable && pwrite && (paddr == ADDR_CLEAR);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_surge_cuts_pwm: assert property (phase_surge |-> !pwm_enable)
        else $error("surge left pwm on");
    a_surge_latches: assert property (phase_surge |-> ##[1:5] fault_active)
        else $error("surge not latched");
    a_fault_blocks: assert property (fault_active && !$past(clr) |-> !pwm_enable)
        else $error("fault left pwm on");
    a_alarm_runs: assert property (alarm_active && !fault_active && !phase_surge
        && !earth_surge |-> (pwm_enable or ##1 fault_active)) else $error("alarm stopped pwm");
    a_fault_holds: assert property ($fell(fault_active) |-> $past(clr) || $past(clr, 2))
        else $error("fault dropped without clear");
    a_under_volt: assert property (meas.supply_class == 2'h0 && meas.link_voltage < UV_LOW
        |-> ##[1:4] fault_active) else $error("undervoltage missed");
    a_over_volt: assert property (meas.supply_class[1] && meas.link_voltage > OV_HIGH
        |-> ##[1:4] fault_active) else $error("overvoltage missed");
    a_module_hot: assert property (meas.module_temp_c >= 16'h007B |-> ##[1:4] fault_active)
        else $error("module overtemp missed");
    a_option_link: assert property (option_present && !option_comm_ok
        |-> ##[1:4] fault_active) else $error("option link fault missed");

    c_fault_alarm: cover property (fault_active && alarm_active);
    c_surge: cover property (phase_surge && !pwm_enable);
    c_cleared: cover property ($fell(fault_active));
endmodule : dps_top_properties

bind dps_top dps_top_properties u_dps_top_properties (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .meas(meas),
    .phase_surge(phase_surge), .earth_surge(earth_surge), .option_present(option_present),
    .option_comm_ok(option_comm_ok), .pwm_enable(pwm_enable),
    .fault_active(fault_active), .alarm_active(alarm_active));

// ### tb/tb.sv
`timescale 1ns/100ps
module tb
    import dps_pkg::*;
;
    localparam logic [15:0] LVL [4]  = '{16'h005A, 16'h0069, 16'h007B, 16'h0078};
    localparam logic [7:0]  MOD [4]  = '{8'h01, 8'h04, 8'h05, 8'h0A};
    localparam logic [15:0] AIV [4]  = '{THERM_HI_MV + 16'h0001, THERM_LO_MV - 16'h0001,
                                         THERM_HI_MV, THERM_LO_MV};
    localparam logic [15:0] UVS [3]  = '{UV_LOW, UV_MID, UV_HIGH};
    localparam logic [15:0] OVS [3]  = '{OV_LOW, OV_MID, OV_HIGH};
    localparam logic [31:0] LE [4]   = '{32'h200, 32'h0, 32'h0, 32'h400};
    localparam logic [14:0] TOG [10] = '{15'h0001, 15'h0002, 15'h0004, 15'h0008, 15'h0010,
                                         15'h0020, 15'h00C0, 15'h0600, 15'h3000, 15'h4000};
    localparam int          BIT [10] = '{8, 0, 1, 3, 4, 5, 11, 12, 13, 14};
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, pwm_enable, fault_active, alarm_active;
    logic [14:0] p = 15'h0880;
    logic [15:0] temp = 16'h0019, volts = 16'h012C, amps = 16'h0000, ai1 = 16'h1388;
    logic [1:0]  cls = 2'h0;
    dps_meas_t   meas;
    int          mismatches = 0, tests_run = 0;

    always #12.5 pclk = ~pclk;

    dps_plant u_dps_plant (.pclk(pclk), .pwm_enable(pwm_enable), .temp_c(temp), .volts(volts),
        .amps(amps), .ai_mv(ai1), .cls(cls), .meas(meas));
    dps_top u_dps_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .meas(meas), .phase_surge(p[0]), .earth_surge(p[1]),
        .module_overload(p[2]), .ext_fault3(p[3]), .ext_fault4(p[4]), .ext_fault5(p[5]),
        .option_present(p[6]), .option_comm_ok(p[7]), .tuning_done(p[8]),
        .stator_edit(p[9]), .stator_too_high(p[10]), .panel_comm_ok(p[11]),
        .hwid_check_done(p[12]), .hwid_check_fail(p[13]), .firmware_error(p[14]),
        .power_hw_model_code_unused(8'h00), .pwm_enable(pwm_enable),
        .fault_active(fault_active), .alarm_active(alarm_active));

    task automatic report_and_stop();
        if (mismatches == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            mismatches++;
            report_and_stop();
        end
        // one idle cycle so the next request never re-drives psel in this step
        @(posedge pclk);
    endtask : apb

    task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask : rchk

    task automatic run(input logic [31:0] ef, input logic [31:0] ea);
        repeat (6) @(posedge pclk);
        rchk("faults", ADDR_FAULTS, ef);
        rchk("alarms", ADDR_ALARMS, ea);
        chk("outputs", {29'h0, ef != 32'h0, ea != 32'h0, ef == 32'h0},
            {29'h0, fault_active, alarm_active, pwm_enable});
    endtask : run

    task automatic clr();
        repeat (3) @(posedge pclk);
        apb(1'b1, ADDR_CLEAR, 32'h0);
    endtask : clr

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk("mask", ADDR_MASK, 32'h3);
        apb(1'b1, ADDR_MASK, 32'hFFFF);
        rchk("mask", ADDR_MASK, 32'hBF);
        rchk("unmapped", 12'hFFC, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        apb(1'b1, ADDR_CONFIG, 32'h40);
        for (int i = 0; i < 4; i++) begin
            ai1 <= AIV[i];
            run(i < 2 ? 32'h4 : 32'h0, 32'h0);
            ai1 <= 16'h1388;
            clr();
        end
        apb(1'b1, ADDR_CONFIG, 32'h400);
        run(32'h4, 32'h0);
        apb(1'b1, ADDR_CONFIG, 32'h0);
        clr();
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_MODEL, {24'h0, MOD[i]});
            temp <= LVL[i] - 16'h0006;
            run(32'h0, 32'h0);
            temp <= LVL[i] - 16'h0005;
            run(32'h0, 32'h1);
            temp <= LVL[i];
            run(32'h80, 32'h1);
            temp <= 16'h0019;
            clr();
        end
        apb(1'b1, ADDR_CONFIG, 32'h0);
        amps <= 16'h0065;
        temp <= 16'h0060;
        run(32'h0, 32'h0);
        rchk("sw_freq", ADDR_SW_FREQ, {16'h0, DERATE_FREQ_HZ});
        apb(1'b1, ADDR_CONFIG, 32'h1);
        apb(1'b1, ADDR_SW_FREQ, {16'h0, SW_FREQ_RESET});
        run(32'h0, 32'h0);
        rchk("sw_freq", ADDR_SW_FREQ, {16'h0, SW_FREQ_RESET});
        amps <= 16'h0000;
        temp <= 16'h0019;
        for (int c = 0; c < 3; c++) begin
            for (int k = 0; k < 4; k++) begin
                cls <= c[1:0];
                volts <= k[1] ? OVS[c] + {15'h0, k[0]} : UVS[c] - {15'h0, ~k[0]};
                run(LE[k], 32'h0);
                volts <= UVS[c] + 16'h000A;
                clr();
            end
        end
        cls <= 2'h0;
        volts <= 16'h012C;
        p <= 15'h0881;
        @(negedge pclk);
        chk("pwm_enable", 32'h0, {31'h0, pwm_enable});
        @(posedge pclk);
        for (int i = 0; i < 10; i++) begin
            p <= 15'h0880 ^ TOG[i];
            run(32'h1 << BIT[i], 32'h0);
            rchk("code", ADDR_CODE, 32'(BIT[i] + 1));
            p <= 15'h0880;
            clr();
        end
        apb(1'b1, ADDR_CONFIG, 32'h4001);
        p <= 15'h0D80;
        run(32'h1000, 32'h0);
        p <= 15'h0880;
        clr();
        apb(1'b1, ADDR_CONFIG, 32'h1000);
        p <= 15'h0080;
        run(32'h0, 32'h2);
        apb(1'b1, ADDR_CONFIG, 32'h3000);
        run(32'h40, 32'h2);
        apb(1'b1, ADDR_MASK, 32'h3F);
        clr();
        run(32'h0, 32'h0);
        report_and_stop();
    end
endmodule : tb
